// *** cw_decoder_map.svh ***
/*
 Constants for the fieldbus control word decoder: field positions, profile codes,
 reset values and timing counts. Assumes the includer runs on a 20 MHz clock.
*/
`ifndef CW_DECODER_MAP_SVH
`define CW_DECODER_MAP_SVH

// Profile codes
`define PROF_BYPASS 2'h0
`define PROF_STANDARD 2'h1
`define PROF_GENERATOR 2'h2

// Bypass profile bit positions
`define BYP_RUN_BIT 0
`define BYP_RESET_BIT 2
`define BYP_DIG_LSB 3

// Standard and generator bit positions
`define STD_CHARGE_BIT 0
`define STD_RUN_BIT 3
`define STD_ACK_BIT 7
`define GEN_REF_LSB 8
`define GEN_ENABLE_BIT 10
`define GEN_WD_BIT 11
`define STD_DIG_LSB 11
`define GEN_DIG_LSB 12

// DC reference selection codes
`define DCREF_FIELDBUS 2'h0
`define DCREF_110 2'h1
`define DCREF_115 2'h2
`define DCREF_120 2'h3

// Reset values
`define CW_RESET 16'h0000
`define PRE_TMO_RESET 16'h0000

// Watchdog delay step in milliseconds and its cycle count at 20 MHz
`define WD_STEP_MS 1
`define CLK_HZ 20000000
`define WD_STEP_CYC ((`CLK_HZ / 1000) * `WD_STEP_MS)

`endif

// *** cw_decoder_pkg.sv ***
/*
 Types shared by the decoder and its watchdog monitor.
 Assumes the constants header is compiled alongside.
*/
`default_nettype none
package cw_decoder_pkg;
  // Selected interpretation of the control word
  typedef enum logic [1:0] {
    prof_bypass = 2'h0,
    prof_standard = 2'h1,
    prof_generator = 2'h2
  } profile_t;

  // Precharge and breaker sequence, Gray coded along the usual path
  typedef enum logic [1:0] {
    brk_open = 2'b00,
    brk_charging = 2'b01,
    brk_closed = 2'b11
  } brk_state_t;

  // Decoded commands leaving the block
  typedef struct packed {
    logic run_request;
    logic start_pulse;
    logic stop_request;
    logic fault_reset_pulse;
    logic precharge_request;
    logic open_breaker_request;
    logic [1:0] dc_ref_select;
    logic [4:0] digital_bits;
  } cmd_t;
endpackage : cw_decoder_pkg
`default_nettype wire

// *** cw_watchdog.sv ***
/*
 Fieldbus watchdog monitor: faults when the pulse bit stops toggling for the delay.
 Assumes a synchronous pulse bit and a delay given in millisecond steps.
*/
`default_nettype none
`include "cw_decoder_map.svh"
module cw_watchdog (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic active,
  input wire logic pulse_bit,
  input wire logic [15:0] delay_ms,
  output logic fault
);
  import cw_decoder_pkg::*;

  // Whole state in one struct
  typedef struct packed {
    logic last;
    logic [15:0] pre;
    logic [15:0] ms;
    logic fault;
  } wd_state_t;

  localparam logic [15:0] STEP_CYC = 16'(`WD_STEP_CYC);

  wd_state_t s_r;
  wd_state_t s_nxt;

  // Counts idle time between toggles; zero delay disables supervision
  always_comb begin
    s_nxt = s_r;
    s_nxt.last = pulse_bit;
    if (!active || delay_ms == 16'h0000) begin
      s_nxt.pre = 16'h0000;
      s_nxt.ms = 16'h0000;
      s_nxt.fault = 1'b0;
    end else if (pulse_bit != s_r.last) begin
      // Toggle seen, restart the timer
      s_nxt.pre = 16'h0000;
      s_nxt.ms = 16'h0000;
    end else if (s_r.pre == STEP_CYC - 16'h0001) begin
      s_nxt.pre = 16'h0000;
      if (s_r.ms == delay_ms - 16'h0001) begin
        s_nxt.fault = 1'b1;
      end else begin
        s_nxt.ms = s_r.ms + 16'h0001;
      end
    end else begin
      s_nxt.pre = s_r.pre + 16'h0001;
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign fault = s_r.fault;

  AST_WD_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && delay_ms == 16'h0000) |=> !fault)
    else $error("watchdog fault with zero delay");
endmodule : cw_watchdog
`default_nettype wire

// *** cw_decoder.sv ***
/*
 Decoder for the 16-bit fieldbus main control word under three profiles.
 Assumes the control word arrives from pins (synchronised here) and the
 profile, settings and drive status come from logic on the same clock.
*/
// What this block does
// - Profile setting selects word interpretation
// - Bypass bit 0 is run request
// - Bypass bit 2 resets fault on rise
// - Pass fieldbus digital bits per profile
// - Bit 0 requests precharge or breaker open
// - Open request opens breaker or aborts precharge
// - Precharge bit needs enable and fieldbus place
// - Standard/generator bit 3 is run request
// - Start only on rising run edge
// - Bit 7 acknowledges faults on rise
// - Generator bits 8-9 pick DC reference
// - Generator bit 10 gates control; drop stops
// - Watchdog faults when pulse stops, delay nonzero
// - Generator bit 15 is ignored
// - Echo watchdog bit in status bit 15
`default_nettype none
`include "cw_decoder_map.svh"
module cw_decoder (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [15:0] main_control_word,
  input wire logic [1:0] profile_setting,
  input wire logic precharge_function_enable,
  input wire logic fieldbus_is_control_place,
  input wire logic ordinary_start,
  input wire logic breaker_closed,
  input wire logic drive_running,
  input wire logic [15:0] watchdog_delay_setting,
  output cw_decoder_pkg::cmd_t cmd,
  output logic precharge_active,
  output logic breaker_close_cmd,
  output logic fieldbus_control_enable,
  output logic watchdog_fault,
  output logic status_watchdog_bit
);
  import cw_decoder_pkg::*;

  // Whole state of the decoder
  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic run_prev;
    logic rst_prev;
    brk_state_t brk;
    cmd_t cmd;
    logic enable;
    logic wd_echo;
  } dec_state_t;

  dec_state_t s_r;
  dec_state_t s_nxt;
  logic wd_active;

  // Map the setting onto a profile; unknown codes fall back to bypass
  function automatic profile_t decode_profile(input logic [1:0] p);
    case (p)
      `PROF_STANDARD: decode_profile = prof_standard;
      `PROF_GENERATOR: decode_profile = prof_generator;
      default: decode_profile = prof_bypass;
    endcase
  endfunction : decode_profile

  profile_t prof;
  assign prof = decode_profile(profile_setting);
  assign wd_active = (prof == prof_generator);

  // Decode the synchronised word
  always_comb begin
    logic [15:0] w;
    logic run_lvl;
    logic rst_lvl;
    logic gate;
    logic pre_req;
    w = s_r.sync2;
    s_nxt = s_r;
    s_nxt.sync1 = main_control_word;
    s_nxt.sync2 = s_r.sync1; // Only the second stage is decoded
    gate = 1'b1;
    run_lvl = 1'b0;
    rst_lvl = 1'b0;
    pre_req = 1'b0;
    s_nxt.cmd.dc_ref_select = `DCREF_FIELDBUS;
    s_nxt.cmd.digital_bits = 5'h00;
    s_nxt.enable = 1'b1;
    s_nxt.wd_echo = 1'b0;
    // Bits outside each profile's table are never looked at
    case (prof)
      prof_bypass: begin
        run_lvl = w[`BYP_RUN_BIT];
        rst_lvl = w[`BYP_RESET_BIT];
        s_nxt.cmd.digital_bits = w[`BYP_DIG_LSB +: 5];
      end
      prof_standard: begin
        run_lvl = w[`STD_RUN_BIT];
        rst_lvl = w[`STD_ACK_BIT];
        pre_req = w[`STD_CHARGE_BIT];
        s_nxt.cmd.digital_bits = {1'b0, w[`STD_DIG_LSB +: 4]};
      end
      prof_generator: begin
        gate = w[`GEN_ENABLE_BIT];
        s_nxt.enable = gate;
        run_lvl = gate & w[`STD_RUN_BIT];
        rst_lvl = gate & w[`STD_ACK_BIT];
        pre_req = gate & w[`STD_CHARGE_BIT];
        s_nxt.cmd.dc_ref_select = w[`GEN_REF_LSB +: 2];
        // Digital bits 2 to 4 sit at positions 1 to 3; bit 15 unused
        s_nxt.cmd.digital_bits = {1'b0, w[`GEN_DIG_LSB +: 3], 1'b0};
        s_nxt.wd_echo = w[`GEN_WD_BIT];
      end
      default: begin
        run_lvl = 1'b0;
      end
    endcase
    // Edges are judged on the gated level, so re-enabling with bit 3 held gives a start
    s_nxt.run_prev = run_lvl;
    s_nxt.rst_prev = rst_lvl;
    s_nxt.cmd.run_request = run_lvl;
    s_nxt.cmd.start_pulse = run_lvl & ~s_r.run_prev;
    s_nxt.cmd.fault_reset_pulse = rst_lvl & ~s_r.rst_prev;
    // Losing the enable while running forces a stop
    s_nxt.cmd.stop_request = ~run_lvl | (~gate & drive_running);
    s_nxt.cmd.precharge_request = 1'b0;
    s_nxt.cmd.open_breaker_request = 1'b0;
    if (prof != prof_bypass) begin
      s_nxt.cmd.open_breaker_request = ~pre_req;
      // Off the fieldbus place, the normal start begins charging
      if (fieldbus_is_control_place) begin
        s_nxt.cmd.precharge_request = pre_req & precharge_function_enable;
      end else begin
        s_nxt.cmd.precharge_request = ordinary_start & precharge_function_enable;
      end
    end
    // Breaker sequence
    case (s_r.brk)
      brk_open: begin
        // Open request wins, so a clashing charge request cannot oscillate
        if (s_r.cmd.precharge_request && !s_r.cmd.open_breaker_request) begin
          s_nxt.brk = brk_charging;
        end
      end
      brk_charging: begin
        if (s_r.cmd.open_breaker_request) begin
          s_nxt.brk = brk_open;
        end else if (breaker_closed) begin
          s_nxt.brk = brk_closed;
        end
      end
      brk_closed: begin
        if (s_r.cmd.open_breaker_request) begin
          s_nxt.brk = brk_open;
        end
      end
      default: begin
        s_nxt.brk = brk_open;
      end
    endcase
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Watchdog supervision only in the generator profile
  cw_watchdog cw_watchdog_i (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .active(wd_active),
    .pulse_bit(s_r.sync2[`GEN_WD_BIT]),
    .delay_ms(watchdog_delay_setting),
    .fault(watchdog_fault)
  );

  assign cmd = s_r.cmd;
  assign precharge_active = (s_r.brk == brk_charging);
  // Closed automatically once charging started
  assign breaker_close_cmd = (s_r.brk != brk_open);
  assign fieldbus_control_enable = s_r.enable;
  assign status_watchdog_bit = s_r.wd_echo;

  // A start pulse is always preceded by a low run level
  AST_START_EDGE: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(ce) && cmd.start_pulse) |-> cmd.run_request && !$past(cmd.run_request))
    else $error("start without rising edge");

  AST_ACK_ONCE: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && cmd.fault_reset_pulse) |=> !cmd.fault_reset_pulse)
    else $error("fault reset held high");

  AST_BYP_RUN: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && prof == prof_bypass) |=> cmd.run_request == $past(s_r.sync2[0]))
    else $error("bypass run mismatch");

  AST_OPEN_ABORT: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && s_r.brk != brk_open && s_r.cmd.open_breaker_request) |=> !breaker_close_cmd)
    else $error("open request ignored");

  AST_NO_BYP_CHARGE: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && prof == prof_bypass) |=> !cmd.precharge_request)
    else $error("precharge in bypass");

  AST_GATE_STOP: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && prof == prof_generator && !s_r.sync2[10] && drive_running) |=> cmd.stop_request)
    else $error("no stop on disable");

  AST_DCREF: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && prof == prof_generator) |=> cmd.dc_ref_select == $past(s_r.sync2[9:8]))
    else $error("dc ref mismatch");

  AST_ECHO: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && prof == prof_generator) |=> status_watchdog_bit == $past(s_r.sync2[11]))
    else $error("watchdog echo mismatch");
endmodule : cw_decoder
`default_nettype wire

// *** fb_master_model.sv ***
/*
 Fieldbus master model: presents the control word and toggles the watchdog bit.
 Assumes the bench sets the word and toggle enable on the same clock.
*/
`default_nettype none
module fb_master_model #(
  parameter int HALF = 2000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] word_set,
  input wire logic wd_on,
  output logic [15:0] main_control_word
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt; // Cycles since last toggle
  logic wd_r; // Watchdog square wave
  // Shortened half period keeps the run brief
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      wd_r <= 1'b0;
    end else if (!wd_on) begin
      cnt <= 0; // Phase restarts with each enable
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      wd_r <= !wd_r;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Bit 11 carries the pulse only while toggling
  always_comb begin
    main_control_word = word_set;
    if (wd_on) begin
      main_control_word[11] = wd_r;
    end
  end
endmodule : fb_master_model
`default_nettype wire

// *** fieldbus_control_word_decoder_test.sv ***
/*
 Self-checking bench for the control word decoder.
 Assumes the decoder and the master model are compiled first.
*/
`default_nettype none
module fieldbus_control_word_decoder_test import cw_decoder_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] word_set = 16'h0000; // Word the master presents
  logic wd_on = 1'b0; // Master toggles bit 11
  logic [1:0] prof = 2'h0;
  logic ce = 1'b1; // Clock enable of the decoder
  logic pre_en = 1'b0;
  logic place = 1'b1;
  logic ord_start = 1'b0;
  logic brk = 1'b0;
  logic running = 1'b0;
  logic [15:0] wd_delay = 16'h0000;
  logic [15:0] mcw;
  cmd_t cmd;
  logic prech, close_cmd, fb_en, wd_fault, wd_echo;
  int err_count = 0;
  int checks = 0;
  int n_start = 0; // Start pulses seen
  int n_rst = 0; // Fault reset pulses seen
  int s0, r0;

  always #25 clk = ~clk;

  fb_master_model fb_master_model_i (.clk(clk), .rst_b(rst_b), .word_set(word_set),
    .wd_on(wd_on), .main_control_word(mcw));
  // Clock enable is dropped once to prove that state freezes
  cw_decoder cw_decoder_i (.clk(clk), .rst_b(rst_b), .ce(ce), .main_control_word(mcw),
    .profile_setting(prof), .precharge_function_enable(pre_en),
    .fieldbus_is_control_place(place), .ordinary_start(ord_start), .breaker_closed(brk),
    .drive_running(running), .watchdog_delay_setting(wd_delay), .cmd(cmd),
    .precharge_active(prech), .breaker_close_cmd(close_cmd),
    .fieldbus_control_enable(fb_en), .watchdog_fault(wd_fault),
    .status_watchdog_bit(wd_echo));

  // Pulses last one cycle, so count them rather than sample
  always @(posedge clk) begin
    if (cmd.start_pulse === 1'b1) n_start <= n_start + 1;
    if (cmd.fault_reset_pulse === 1'b1) n_rst <= n_rst + 1;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Write a word, then wait past the sync and register latency
  task automatic put(input logic [15:0] w);
    @(posedge clk);
    word_set <= w;
    repeat (6) @(posedge clk);
    #1;
  endtask : put

  task automatic results;
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // Hang guard, well past the expected run of about 50000 cycles
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    results();
  end

  initial begin
    repeat (10) @(posedge clk);
    chk("cmd_rst", 16'(cmd), 16'h0000);
    rst_b <= 1'b1;
    // Bypass profile
    put(16'h00F8);
    chk("byp_dig", 16'(cmd.digital_bits), 16'h001F);
    s0 = n_start;
    r0 = n_rst;
    put(16'h00F9);
    put(16'h00FD);
    put(16'h00FD);
    chk("byp_run", 16'(cmd.run_request), 16'h0001);
    chk("byp_start", 16'(n_start - s0), 16'h0001);
    chk("byp_reset", 16'(n_rst - r0), 16'h0001);
    // Standard profile: bit 2 now undefined
    prof <= 2'h1;
    put(16'h0000);
    s0 = n_start;
    r0 = n_rst;
    put(16'h0004);
    put(16'h7808);
    chk("std_dig", 16'(cmd.digital_bits), 16'h000F);
    put(16'h7888);
    put(16'h7888);
    chk("std_start", 16'(n_start - s0), 16'h0001);
    chk("std_ack", 16'(n_rst - r0), 16'h0001);
    // Frozen: a new word must not get through
    ce <= 1'b0;
    put(16'h0000);
    chk("ce_hold", 16'(cmd.run_request), 16'h0001);
    ce <= 1'b1;
    // Precharge, close, open, abort
    pre_en <= 1'b1;
    put(16'h0001);
    chk("pre_req", 16'(cmd.precharge_request), 16'h0001);
    chk("pre_act", 16'(prech), 16'h0001);
    brk <= 1'b1;
    put(16'h0001);
    chk("closed", 16'({prech, close_cmd}), 16'h0001);
    put(16'h0000);
    chk("open_req", 16'(cmd.open_breaker_request), 16'h0001);
    chk("open_cmd", 16'(close_cmd), 16'h0000);
    brk <= 1'b0;
    put(16'h0001);
    chk("recharge", 16'(prech), 16'h0001);
    put(16'h0000);
    chk("abort", 16'(prech), 16'h0000);
    pre_en <= 1'b0;
    put(16'h0001);
    chk("pre_off", 16'(prech), 16'h0000);
    pre_en <= 1'b1;
    place <= 1'b0;
    ord_start <= 1'b1;
    put(16'h0001);
    chk("pre_local", 16'(prech), 16'h0001);
    ord_start <= 1'b0;
    place <= 1'b1;
    // Generator profile: every reference code, bit 15 set
    prof <= 2'h2;
    for (int i = 0; i < 4; i++) begin
      put(16'h8400 | 16'(i << 8));
      chk("dc_ref", 16'(cmd.dc_ref_select), 16'(i));
      chk("gen_dig", 16'(cmd.digital_bits), 16'h0000);
    end
    chk("fb_en", 16'(fb_en), 16'h0001);
    put(16'h7400);
    chk("gen_dig", 16'(cmd.digital_bits), 16'h000E);
    running <= 1'b1;
    s0 = n_start;
    put(16'h7408);
    chk("gen_start", 16'(n_start - s0), 16'h0001);
    put(16'h7008);
    chk("gen_stop", 16'(cmd.stop_request), 16'h0001);
    chk("fb_dis", 16'(fb_en), 16'h0000);
    running <= 1'b0;
    // Watchdog echo and supervision
    put(16'h0C00);
    chk("echo", 16'(wd_echo), 16'h0001);
    wd_delay <= 16'h0001;
    wd_on <= 1'b1;
    repeat (25000) @(posedge clk);
    #1;
    chk("wd_ok", 16'(wd_fault), 16'h0000);
    chk("echo_t", 16'(wd_echo), 16'(mcw[11]));
    wd_on <= 1'b0;
    repeat (21000) @(posedge clk);
    #1;
    chk("wd_trip", 16'(wd_fault), 16'h0001);
    wd_delay <= 16'h0000;
    repeat (4) @(posedge clk);
    #1;
    chk("wd_off", 16'(wd_fault), 16'h0000);
    results();
  end
endmodule : fieldbus_control_word_decoder_test
`default_nettype wire
